// ### verilog/wcr_pkg.sv
package wcr_pkg;
   // ======================================
   // Timing
   localparam int CLK_HZ = 250_000_000;
   localparam int MAINS_HZ = 60;
   localparam int VALVE_TIME_MS = 500;
   localparam int VALVE_MAINS = VALVE_TIME_MS * MAINS_HZ / 1000;
   localparam int MAINS_DIV = CLK_HZ / MAINS_HZ;
   // ======================================
   // Mode codes, two BCD digits
   localparam logic [7:0] MODE_OFF = 8'h00;
   localparam logic [7:0] MODE_PA_COMP = 8'h10;
   localparam logic [7:0] MODE_PA_MON = 8'h11;
   localparam logic [7:0] MODE_PP_COMP0 = 8'h12;
   localparam logic [7:0] MODE_PP_MON0 = 8'h13;
   localparam logic [7:0] MODE_PP_COMP1 = 8'h14;
   localparam logic [7:0] MODE_PP_MON1 = 8'h15;
   localparam logic [7:0] MODE_PP_COMP2 = 8'h16;
   localparam logic [7:0] MODE_PP_MON2 = 8'h17;
   localparam logic [7:0] MODE_PP_COMP3 = 8'h18;
   localparam logic [7:0] MODE_PP_MON3 = 8'h19;
   localparam logic [7:0] MODE_SA_COMP = 8'h30;
   localparam logic [7:0] MODE_SA_MON = 8'h31;
   localparam logic [7:0] MODE_SP_COMP = 8'h32;
   localparam logic [7:0] MODE_SP_MON = 8'h33;
   localparam logic [15:0] RANGE_PCT = 16'h0099;
   // ======================================
   // Process output codes
   localparam logic [7:0] PO_READOUT = 8'h12;
   localparam logic [7:0] PO_ALARM = 8'h13;
   // ======================================
   // Register map and reset values
   localparam logic [3:0] REG_MODE = 4'h0;
   localparam logic [3:0] REG_RANGE = 4'h1;
   localparam logic [3:0] REG_POUT = 4'h2;
   localparam logic [3:0] REG_STATUS = 4'h3;
   localparam logic [3:0] REG_CURRENT = 4'h4;
   localparam logic [3:0] REG_PHASE = 4'h5;
   localparam logic [3:0] REG_LEARN = 4'h6;
   localparam logic [7:0] MODE_RST = MODE_OFF;
   localparam logic [15:0] RANGE_RST = RANGE_PCT;
   localparam logic [7:0] POUT_RST = 8'h00;
   typedef enum logic [2:0] {
      VIEW_IDLE = 3'b000,
      VIEW_CURRENT = 3'b001,
      VIEW_PHASE = 3'b010,
      VIEW_PERCENT = 3'b011,
      VIEW_TAP_UP = 3'b100,
      VIEW_TAP_DN = 3'b101,
      VIEW_LIMIT = 3'b110
   } wcr_view_type;
endpackage : wcr_pkg

// ### verilog/wcr_mode_if.sv
`timescale 1ns/10ps
interface wcr_mode_if;
   logic [7:0] mode;
   logic [15:0] range;
   logic [15:0] learn_max;
   logic cc_on;
   logic comp_en;
   logic sp_ka;
   logic auto_range;
   logic [2:0] gain;
   modport dec (
      input mode, range, learn_max,
      output cc_on, comp_en, sp_ka, auto_range, gain
   );
   modport user (
      output mode, range, learn_max,
      input cc_on, comp_en, sp_ka, auto_range, gain
   );
endinterface : wcr_mode_if

// ### verilog/wcr_mode_dec.sv
`timescale 1ns/10ps
module wcr_mode_dec
   import wcr_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   wcr_mode_if.dec mif
);
   typedef struct packed {
      logic cc_on;
      logic comp_en;
      logic sp_ka;
      logic auto_range;
      logic [2:0] gain;
   } wcr_dec_type;

   wcr_dec_type s;
   wcr_dec_type next_s;

   // ======================================
   // Gain selection
   // Larger full scale needs less amplifier gain
   function automatic logic [2:0] level_gain(input logic [3:0] d);
      if (d >= 4'h8) return 3'h0;
      else if (d >= 4'h4) return 3'h1;
      else if (d >= 4'h2) return 3'h2;
      else if (d >= 4'h1) return 3'h3;
      else return 3'h4;
   endfunction : level_gain

   function automatic logic [2:0] size_gain(input logic [7:0] m);
      return 3'h4 + {1'b0, 2'(m[3:1] - 3'h1)};
   endfunction : size_gain

   always_comb begin
      next_s = '0;
      case (mif.mode)
         MODE_OFF: begin
            next_s = '0;
         end
         MODE_PA_COMP, MODE_SA_COMP: begin
            next_s.cc_on = 1'b1;
            next_s.comp_en = 1'b1;
            next_s.auto_range = 1'b1;
            next_s.sp_ka = (mif.range != RANGE_PCT);
            next_s.gain = level_gain(mif.learn_max[15:12]);
         end
         MODE_PA_MON, MODE_SA_MON: begin
            next_s.cc_on = 1'b1;
            next_s.auto_range = 1'b1;
            next_s.gain = level_gain(mif.learn_max[15:12]);
         end
         MODE_SP_COMP: begin
            next_s.cc_on = 1'b1;
            next_s.comp_en = 1'b1;
            next_s.sp_ka = 1'b1;
            next_s.gain = level_gain(mif.range[15:12]);
         end
         MODE_SP_MON: begin
            next_s.cc_on = 1'b1;
            next_s.gain = level_gain(mif.range[15:12]);
         end
         MODE_PP_COMP0, MODE_PP_COMP1, MODE_PP_COMP2, MODE_PP_COMP3: begin
            next_s.cc_on = 1'b1;
            next_s.comp_en = 1'b1;
            next_s.sp_ka = 1'b1;
            next_s.gain = size_gain(mif.mode);
         end
         MODE_PP_MON0, MODE_PP_MON1, MODE_PP_MON2, MODE_PP_MON3: begin
            next_s.cc_on = 1'b1;
            next_s.gain = size_gain(mif.mode);
         end
         default: begin
            next_s = '0;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) s <= '0;
      else s <= next_s;
   end

   assign mif.cc_on = s.cc_on;
   assign mif.comp_en = s.comp_en;
   assign mif.sp_ka = s.sp_ka;
   assign mif.auto_range = s.auto_range;
   assign mif.gain = s.gain;

   // ======================================
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   chk_off_quiet: assert property (
      mif.mode == MODE_OFF |=> !mif.cc_on && !mif.comp_en)
      else $error("Mode off still drives compensation");
   chk_unknown_mode: assert property (
      (mif.mode == 8'h20 || mif.mode == 8'h99) |=> !mif.cc_on && !mif.comp_en)
      else $error("Unknown mode enabled compensation");
   chk_auto_pct: assert property (
      (mif.mode == MODE_SA_COMP || mif.mode == MODE_PA_COMP) && mif.range == RANGE_PCT
      |=> mif.comp_en && !mif.sp_ka && mif.auto_range)
      else $error("Auto range percent setpoint wrong");
   chk_monitor_pct: assert property (
      (mif.mode == MODE_PP_MON2 || mif.mode == MODE_SA_MON || mif.mode == MODE_PA_MON)
      |=> mif.cc_on && !mif.comp_en && !mif.sp_ka)
      else $error("Monitor mode compensates or uses kA");
   chk_sp_ka: assert property (
      mif.mode == MODE_SP_COMP |=> mif.comp_en && mif.sp_ka && !mif.auto_range)
      else $error("Secondary preset compensation not in kA");
endmodule : wcr_mode_dec

// ### verilog/wcr_readout.sv
`timescale 1ns/10ps
// Overview of operation
// - Gain follows chosen mode and range automatically
// - Codes 13 to 19 odd: preset monitoring
// - Auto modes learn peak output current
// - Code 30: auto compensation, range 0099 percent
// - Code 31: secondary auto monitoring, percent setpoint
// - Code 10: primary auto compensation, kA option
// - Code 11: primary auto monitoring, percent
// - Current selected before start shows readout
// - kA readout at weld end only in kA mode, weld made
// - Units shows phase, tens current, other clears
// - Phase view only from current readout
// - Tap up shown when more output needed
// - Tap down shown when current exceeds range
// - Tap views still allow phase and current
// - Readout process output shows readout whenever constant current is on
// - Limit failure flashes low or high indication
// - Alarm output drives valve thirty mains cycles
// - Code 32: secondary preset compensation in kA
// - Code 00 disables constant current
module wcr_readout
   import wcr_pkg::*;
#(
   parameter int MAINS_DIV_P = MAINS_DIV
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic seq_init,
   input wire logic cur_selected,
   input wire logic seq_end,
   input wire logic weld_made,
   input wire logic [15:0] meas_current,
   input wire logic [7:0] phase_pct,
   input wire logic need_more,
   input wire logic over_range,
   input wire logic limit_low,
   input wire logic limit_high,
   input wire logic learn_run,
   input wire logic learn_valid,
   input wire logic [15:0] learn_sample,
   input wire logic btn_units,
   input wire logic btn_tens,
   input wire logic btn_other,
   output logic [2:0] gain_sel,
   output logic comp_en,
   output logic setpoint_in_ka,
   output logic [2:0] disp_view,
   output logic [15:0] disp_value,
   output logic disp_flash,
   output logic tap_up_indicator,
   output logic tap_down_indicator,
   output logic alarm_valve
);
   typedef struct packed {
      logic [7:0] mode;
      logic [15:0] range;
      logic [7:0] pout;
      logic [15:0] cur;
      logic [7:0] phase;
      logic [15:0] learn_max;
      logic learn_prev;
      wcr_view_type view;
      logic tap_up;
      logic tap_dn;
      logic lim_lo;
      logic lim_hi;
      logic sel_cur;
      logic [31:0] div;
      logic mains_tick;
      logic [4:0] valve_cnt;
      logic [15:0] rdata;
      logic [15:0] disp;
   } wcr_top_state_type;

   wcr_top_state_type s;
   wcr_top_state_type next_s;
   logic [1:0] rst_sync;
   logic rst_n;
   logic po_ro;
   logic show;
   logic any_btn;
   wcr_mode_if mi ();

   // ======================================
   // Reset release
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) rst_sync <= 2'b00;
      else rst_sync <= {rst_sync[0], 1'b1};
   end
   assign rst_n = rst_sync[1];

   // ======================================
   // Mode decode
   assign mi.mode = s.mode;
   assign mi.range = s.range;
   assign mi.learn_max = s.learn_max;

   wcr_mode_dec u_dec (
      .mclk(mclk),
      .rst_n(rst_n),
      .mif(mi)
   );

   // ======================================
   // Sequence and display control
   assign po_ro = (s.pout == PO_READOUT) || (s.pout == PO_ALARM);
   assign show = mi.cc_on && (s.sel_cur || po_ro);
   assign any_btn = btn_units || btn_tens || btn_other;

   always_comb begin
      next_s = s;
      next_s.mains_tick = 1'b0;
      next_s.rdata = '0;
      // Mains cycle time base
      if (s.div >= 32'(MAINS_DIV_P - 1)) begin
         next_s.div = '0;
         next_s.mains_tick = 1'b1;
      end else begin
         next_s.div = s.div + 32'h1;
      end
      if (reg_wr) begin
         case (reg_addr)
            REG_MODE: next_s.mode = reg_wdata[7:0];
            REG_RANGE: next_s.range = reg_wdata;
            REG_POUT: next_s.pout = reg_wdata[7:0];
            default: ;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            REG_MODE: next_s.rdata = {8'h00, s.mode};
            REG_RANGE: next_s.rdata = s.range;
            REG_POUT: next_s.rdata = {8'h00, s.pout};
            REG_STATUS: next_s.rdata = {4'h0, s.view, alarm_valve, s.lim_hi, s.lim_lo,
                                        s.tap_dn, s.tap_up, mi.auto_range, mi.sp_ka,
                                        mi.comp_en, mi.cc_on};
            REG_CURRENT: next_s.rdata = s.cur;
            REG_PHASE: next_s.rdata = {8'h00, s.phase};
            REG_LEARN: next_s.rdata = s.learn_max;
            default: next_s.rdata = '0;
         endcase
      end
      // Peak of the learning run is the compensation reference
      next_s.learn_prev = learn_run;
      if (mi.auto_range && learn_run) begin
         if (!s.learn_prev) next_s.learn_max = learn_valid ? learn_sample : 16'h0000;
         else if (learn_valid && learn_sample > s.learn_max) next_s.learn_max = learn_sample;
      end
      if (s.valve_cnt != 5'h00 && s.mains_tick) begin
         next_s.valve_cnt = s.valve_cnt - 5'h01;
      end
      // Front panel keys while a readout stands
      case (s.view)
         VIEW_CURRENT, VIEW_PHASE, VIEW_TAP_UP, VIEW_TAP_DN: begin
            if (btn_units) next_s.view = VIEW_PHASE;
            else if (btn_tens) next_s.view = VIEW_CURRENT;
            else if (btn_other) next_s.view = VIEW_IDLE;
         end
         VIEW_PERCENT, VIEW_LIMIT: begin
            if (any_btn) next_s.view = VIEW_IDLE;
         end
         default: ;
      endcase
      if (seq_init) begin
         next_s.sel_cur = cur_selected;
         next_s.view = VIEW_IDLE;
      end
      // End of sequence wins over a key in the same cycle
      if (seq_end) begin
         next_s.cur = meas_current;
         next_s.phase = phase_pct;
         next_s.tap_up = mi.comp_en && need_more;
         next_s.tap_dn = mi.comp_en && over_range && !need_more;
         next_s.lim_lo = show && po_ro && limit_low;
         next_s.lim_hi = show && po_ro && limit_high && !limit_low;
         next_s.view = VIEW_IDLE;
         if (show) begin
            if (next_s.tap_up) next_s.view = VIEW_TAP_UP;
            else if (next_s.tap_dn) next_s.view = VIEW_TAP_DN;
            else if (next_s.lim_lo || next_s.lim_hi) next_s.view = VIEW_LIMIT;
            else if (mi.sp_ka && weld_made) next_s.view = VIEW_CURRENT;
            else next_s.view = VIEW_PERCENT;
            if ((next_s.lim_lo || next_s.lim_hi) && s.pout == PO_ALARM) begin
               next_s.valve_cnt = 5'(VALVE_MAINS);
            end
         end
      end
      if (next_s.view == VIEW_IDLE) begin
         next_s.tap_up = 1'b0;
         next_s.tap_dn = 1'b0;
         next_s.lim_lo = 1'b0;
         next_s.lim_hi = 1'b0;
      end
      case (next_s.view)
         VIEW_IDLE: next_s.disp = '0;
         VIEW_PHASE: next_s.disp = {8'h00, next_s.phase};
         default: next_s.disp = next_s.cur;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
         s.mode <= MODE_RST;
         s.range <= RANGE_RST;
         s.pout <= POUT_RST;
         s.view <= VIEW_IDLE;
      end else begin
         s <= next_s;
      end
   end

   // ======================================
   // Outputs
   assign reg_rdata = s.rdata;
   assign gain_sel = mi.gain;
   assign comp_en = mi.comp_en;
   assign setpoint_in_ka = mi.sp_ka;
   assign disp_view = s.view;
   assign disp_value = s.disp;
   assign disp_flash = (s.view == VIEW_LIMIT);
   assign tap_up_indicator = s.tap_up;
   assign tap_down_indicator = s.tap_dn;
   assign alarm_valve = (s.valve_cnt != 5'h00);

   // ======================================
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence seq_fail_alarm;
      seq_end && show && s.pout == PO_ALARM && (limit_low || limit_high)
      && !(mi.comp_en && (need_more || over_range));
   endsequence
   sequence seq_rms_shown;
      s.view == VIEW_CURRENT || s.view == VIEW_TAP_UP
      || s.view == VIEW_TAP_DN;
   endsequence

   chk_valve_load: assert property (
      seq_fail_alarm
      |=> s.valve_cnt == 5'h1e && alarm_valve && disp_flash)
      else $error("Alarm valve not started for 30 mains cycles");

   chk_phase_gate: assert property (
      seq_rms_shown ##0 (btn_units && !seq_end && !seq_init)
      |=> s.view == VIEW_PHASE)
      else $error("Units key did not open phase view");

   chk_phase_src: assert property (
      $rose(s.view == VIEW_PHASE) |-> $past(btn_units)
      && ($past(s.view) == VIEW_CURRENT || $past(s.view) == VIEW_TAP_UP
      || $past(s.view) == VIEW_TAP_DN))
      else $error("Phase view entered without current readout");

   chk_other_clear: assert property (
      s.view != VIEW_IDLE && btn_other && !btn_units && !btn_tens && !seq_end
      |=> s.view == VIEW_IDLE && disp_value == 16'h0000)
      else $error("Other key did not clear readout");

   chk_ka_weld: assert property (
      seq_end ##1 s.view == VIEW_CURRENT
      |-> $past(weld_made) && $past(mi.sp_ka))
      else $error("kA readout without weld or kA mode");

   chk_tap_up: assert property (
      $rose(tap_up_indicator)
      |-> $past(seq_end && mi.comp_en && need_more))
      else $error("Tap up raised without cause");

   chk_tap_dn: assert property (
      seq_end && show && mi.comp_en && over_range && !need_more
      |=> tap_down_indicator && s.view == VIEW_TAP_DN)
      else $error("Tap down not shown");

   chk_tap_keys: assert property (
      (s.view == VIEW_TAP_UP || s.view == VIEW_TAP_DN) && btn_tens && !btn_units
      && !seq_end && !seq_init |=> s.view == VIEW_CURRENT && disp_value == $past(s.cur))
      else $error("Tens key lost the tap readout");

   chk_idle_taps: assert property (
      seq_end && !mi.cc_on
      |=> !tap_up_indicator && !tap_down_indicator && s.view == VIEW_IDLE)
      else $error("Disabled mode raised an indicator");

   chk_po_readout: assert property (
      seq_end && mi.cc_on && po_ro |=> s.view != VIEW_IDLE ##1 s.view != VIEW_IDLE
      || $past(any_btn || seq_init))
      else $error("Readout output gave no readout");

   chk_sel_readout: assert property (
      seq_end && mi.cc_on && s.sel_cur |=> s.view != VIEW_IDLE && disp_value == $past(meas_current)
      || s.view == VIEW_PHASE)
      else $error("Selected current gave no readout");

   chk_learn_peak: assert property (
      mi.auto_range && learn_run && s.learn_prev && learn_valid
      && learn_sample > s.learn_max |=> s.learn_max == $past(learn_sample))
      else $error("Learning peak not recorded");

   chk_rdata_idle: assert property (
      !reg_rd
      |=> reg_rdata == 16'h0000)
      else $error("Read data stood without a read");

   // ======================================
   // Alarm valve checks
   // Clocks with the valve on; a new weld restarts the count
   logic [31:0] valve_clks;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) valve_clks <= 32'h0;
      else if (!alarm_valve || seq_end) valve_clks <= 32'h0;
      else valve_clks <= valve_clks + 32'h1;
   end

   chk_valve_step: assert property (
      alarm_valve && s.mains_tick && !seq_end
      |=> s.valve_cnt == $past(s.valve_cnt) - 5'h01)
      else $error("Valve count missed a mains tick");

   chk_valve_time: assert property (
      alarm_valve |-> valve_clks < 32'(VALVE_MAINS * MAINS_DIV_P))
      else $error("Alarm valve held past 30 mains cycles");

   chk_lim_prio: assert property (
      seq_end && show && po_ro && limit_low
      |=> s.lim_lo && !s.lim_hi)
      else $error("Low limit lost priority");
endmodule : wcr_readout

// ### verif/wcr_panel_model.sv
`timescale 1ns/10ps
// ======================================
// Front panel and current sensor
module wcr_panel_model (
   input wire logic mclk,
   output logic seq_init,
   output logic cur_selected,
   output logic seq_end,
   output logic weld_made,
   output logic [15:0] meas_current,
   output logic [7:0] phase_pct,
   output logic need_more,
   output logic over_range,
   output logic limit_low,
   output logic limit_high,
   output logic learn_run,
   output logic learn_valid,
   output logic [15:0] learn_sample,
   output logic btn_units,
   output logic btn_tens,
   output logic btn_other
);
   initial begin
      {seq_init, cur_selected, seq_end, weld_made, need_more, over_range} = 6'h00;
      {limit_low, limit_high, learn_run, learn_valid} = 4'h0;
      {btn_units, btn_tens, btn_other} = 3'h0;
      meas_current = 16'h0000;
      phase_pct = 8'h00;
      learn_sample = 16'h0000;
   end
   // Weld: start, three cycles, then end with sensor results
   task automatic weld(input logic sel, input logic made, input logic [3:0] flg,
                       input logic [15:0] cur, input logic [7:0] ph);
      @(posedge mclk);
      seq_init <= 1'b1;
      cur_selected <= sel;
      @(posedge mclk);
      seq_init <= 1'b0;
      @(posedge mclk);
      @(posedge mclk);
      seq_end <= 1'b1;
      weld_made <= made;
      {need_more, over_range, limit_low, limit_high} <= flg;
      meas_current <= cur;
      phase_pct <= ph;
      @(posedge mclk);
      seq_end <= 1'b0;
      // Sensor results no longer held: show the inverse, not stale data
      meas_current <= ~cur;
      phase_pct <= ~ph;
      {need_more, over_range, limit_low, limit_high} <= ~flg;
      weld_made <= ~made;
      #1;
   endtask : weld
   // Key 0 units, 1 tens, 2 other
   task automatic key(input int k);
      @(posedge mclk);
      {btn_other, btn_tens, btn_units} <= 3'b001 << k;
      @(posedge mclk);
      {btn_other, btn_tens, btn_units} <= 3'b000;
      #1;
   endtask : key
   // Learning run with two samples
   task automatic learn(input logic [15:0] a, input logic [15:0] b);
      @(posedge mclk);
      learn_run <= 1'b1;
      @(posedge mclk);
      learn_valid <= 1'b1;
      learn_sample <= a;
      @(posedge mclk);
      learn_sample <= b;
      @(posedge mclk);
      learn_valid <= 1'b0;
      learn_run <= 1'b0;
      learn_sample <= ~b;
   endtask : learn
endmodule : wcr_panel_model

// ### verif/tb.sv
`timescale 1ns/10ps
module tb
   import wcr_pkg::*;
;
   logic mclk = 1'b0;
   logic arst_n;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [15:0] reg_rdata;
   logic seq_init, cur_selected, seq_end, weld_made, need_more, over_range;
   logic limit_low, limit_high, learn_run, learn_valid;
   logic btn_units, btn_tens, btn_other;
   logic [15:0] meas_current, learn_sample, disp_value;
   logic [7:0] phase_pct;
   logic [2:0] gain_sel, disp_view;
   logic comp_en, setpoint_in_ka, disp_flash, tap_up_indicator, tap_down_indicator;
   logic alarm_valve;
   int err_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   // ======================================
   // Clock, design and partner
   always #2 mclk = ~mclk;
   wcr_readout #(.MAINS_DIV_P(4)) wcr_readout_inst (
      .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .seq_init(seq_init), .cur_selected(cur_selected), .seq_end(seq_end),
      .weld_made(weld_made), .meas_current(meas_current), .phase_pct(phase_pct),
      .need_more(need_more), .over_range(over_range), .limit_low(limit_low),
      .limit_high(limit_high), .learn_run(learn_run), .learn_valid(learn_valid),
      .learn_sample(learn_sample), .btn_units(btn_units), .btn_tens(btn_tens),
      .btn_other(btn_other), .gain_sel(gain_sel), .comp_en(comp_en),
      .setpoint_in_ka(setpoint_in_ka), .disp_view(disp_view), .disp_value(disp_value),
      .disp_flash(disp_flash), .tap_up_indicator(tap_up_indicator),
      .tap_down_indicator(tap_down_indicator), .alarm_valve(alarm_valve));
   wcr_panel_model wcr_panel_model_inst (
      .mclk(mclk), .seq_init(seq_init), .cur_selected(cur_selected), .seq_end(seq_end),
      .weld_made(weld_made), .meas_current(meas_current), .phase_pct(phase_pct),
      .need_more(need_more), .over_range(over_range), .limit_low(limit_low),
      .limit_high(limit_high), .learn_run(learn_run), .learn_valid(learn_valid),
      .learn_sample(learn_sample), .btn_units(btn_units), .btn_tens(btn_tens),
      .btn_other(btn_other));
   // ======================================
   // Bus and compare helpers
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask : rd
   // Decoder needs two edges after the write; one spare
   task automatic setup(input logic [7:0] m, input logic [15:0] r, input logic [7:0] p);
      wr(REG_MODE, {8'h00, m});
      wr(REG_RANGE, r);
      wr(REG_POUT, {8'h00, p});
      repeat (3) @(posedge mclk);
      #1;
   endtask : setup
   task automatic view(input logic [2:0] v, input logic [15:0] val);
      chk({13'h0, disp_view}, {13'h0, v});
      chk(disp_value, val);
   endtask : view
   // ======================================
   // Scenarios
   task automatic t_modes;
      logic [7:0] m [14] = '{8'h00, 8'h10, 8'h10, 8'h11, 8'h13, 8'h15, 8'h17, 8'h19,
                             8'h12, 8'h33, 8'h30, 8'h30, 8'h31, 8'h32};
      logic [15:0] r [14] = '{16'h0099, 16'h0099, 16'h1500, 16'h1500, 16'h0099, 16'h0099,
                              16'h0099, 16'h0099, 16'h0099, 16'h2000, 16'h0099, 16'h2000,
                              16'h2000, 16'h2000};
      logic [1:0] e [14] = '{2'b00, 2'b10, 2'b11, 2'b00, 2'b00, 2'b00, 2'b00, 2'b00,
                             2'b11, 2'b00, 2'b10, 2'b11, 2'b00, 2'b11};
      for (int i = 0; i < 14; i++) begin
         setup(m[i], r[i], 8'h00);
         chk({14'h0, comp_en, setpoint_in_ka}, {14'h0, e[i]});
      end
      chk({13'h0, gain_sel}, 16'h0002);
      setup(8'h55, 16'h1500, 8'h00);
      chk({14'h0, comp_en, setpoint_in_ka}, 16'h0000);
      wcr_panel_model_inst.weld(1'b1, 1'b1, 4'h8, 16'h0123, 8'h11);
      chk({12'h0, tap_up_indicator, disp_view}, 16'h0000);
      rd(REG_MODE, 16'h0055);
      rd(4'h9, 16'h0000);
   endtask : t_modes
   task automatic t_readout;
      setup(MODE_PA_COMP, 16'h1500, 8'h00);
      wcr_panel_model_inst.weld(1'b1, 1'b1, 4'h0, 16'h1234, 8'h56);
      view(3'd1, 16'h1234);
      rd(REG_CURRENT, 16'h1234);
      rd(REG_PHASE, 16'h0056);
      wcr_panel_model_inst.key(0);
      view(3'd2, 16'h0056);
      wcr_panel_model_inst.key(1);
      view(3'd1, 16'h1234);
      wcr_panel_model_inst.key(2);
      view(3'd0, 16'h0000);
      wcr_panel_model_inst.weld(1'b1, 1'b0, 4'h0, 16'h0042, 8'h50);
      view(3'd3, 16'h0042);
      wcr_panel_model_inst.key(0);
      chk({13'h0, disp_view}, 16'h0000);
      wcr_panel_model_inst.weld(1'b0, 1'b1, 4'h0, 16'h0777, 8'h50);
      chk({13'h0, disp_view}, 16'h0000);
      setup(MODE_PA_COMP, 16'h1500, PO_READOUT);
      wcr_panel_model_inst.weld(1'b0, 1'b1, 4'h0, 16'h0888, 8'h50);
      view(3'd1, 16'h0888);
   endtask : t_readout
   task automatic t_taps;
      setup(MODE_PA_COMP, 16'h1500, 8'h00);
      wcr_panel_model_inst.weld(1'b1, 1'b1, 4'h8, 16'h0900, 8'h99);
      chk({13'h0, disp_view}, 16'h0004);
      chk({15'h0, tap_up_indicator}, 16'h0001);
      wcr_panel_model_inst.key(0);
      view(3'd2, 16'h0099);
      wcr_panel_model_inst.key(2);
      chk({14'h0, disp_view[0], tap_up_indicator}, 16'h0000);
      wcr_panel_model_inst.weld(1'b1, 1'b1, 4'h4, 16'h1900, 8'h20);
      chk({15'h0, tap_down_indicator}, 16'h0001);
      chk({13'h0, disp_view}, 16'h0005);
      wcr_panel_model_inst.key(1);
      view(3'd1, 16'h1900);
      setup(MODE_SA_MON, 16'h0099, 8'h00);
      wcr_panel_model_inst.weld(1'b1, 1'b1, 4'h8, 16'h0050, 8'h99);
      chk({14'h0, tap_up_indicator, tap_down_indicator}, 16'h0000);
   endtask : t_taps
   task automatic t_limits;
      int n;
      setup(MODE_PA_COMP, 16'h1500, PO_READOUT);
      wcr_panel_model_inst.weld(1'b0, 1'b1, 4'h1, 16'h1300, 8'h70);
      chk({13'h0, disp_view}, 16'h0006);
      chk({14'h0, disp_flash, alarm_valve}, 16'h0002);
      wcr_panel_model_inst.key(2);
      setup(MODE_PA_COMP, 16'h1500, PO_ALARM);
      wcr_panel_model_inst.weld(1'b0, 1'b1, 4'h2, 16'h1100, 8'h70);
      chk({14'h0, disp_flash, alarm_valve}, 16'h0003);
      n = 0;
      while (alarm_valve === 1'b1 && n < 400) begin
         @(posedge mclk);
         #1;
         n++;
      end
      // Free running tick: 29 to 30 mains periods of 4 clocks
      chk(16'(n >= 116 && n <= 120), 16'h0001);
      rd(REG_STATUS, 16'h0c4f);
      rd(REG_POUT, 16'h0013);
   endtask : t_limits
   task automatic t_learn;
      setup(MODE_SA_COMP, 16'h0099, 8'h00);
      wcr_panel_model_inst.learn(16'h2000, 16'h8100);
      rd(REG_LEARN, 16'h8100);
      chk({13'h0, gain_sel}, 16'h0000);
   endtask : t_learn
   // ======================================
   // Sequencing and verdict
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         wrap_up();
      end
   end
   initial begin
      arst_n = 1'b0;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = 22'h000000;
      repeat (12) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      #1;
      chk({14'h0, comp_en, setpoint_in_ka}, 16'h0000);
      rd(REG_RANGE, RANGE_RST);
      t_modes();
      t_readout();
      t_taps();
      t_limits();
      t_learn();
      wrap_up();
   end
endmodule : tb
